/* File: include/dser_pkg.sv */
package dser_pkg;
  // Register offsets
  localparam logic [7:0] DSER_STRAP_STATUS_OFS = 8'h37;
  localparam logic [7:0] DSER_AUDIO_DIV_OFS = 8'h3a;
  localparam logic [7:0] DSER_EQUALIZER_SETTING_STATUS_OFS = 8'h3b;
  localparam logic [7:0] DSER_LINK_ERR_OFS = 8'h41;

  // Field positions, strap_decode_status
  localparam int DSER_RATE_DONE_BIT = 7;
  localparam int DSER_RATE_LSB = 4;
  localparam int DSER_OUT_DONE_BIT = 3;
  localparam int DSER_OUT_LSB = 0;
  // Field positions, audio_clock_divider_select
  localparam int DSER_AUDIO_OV_BIT = 7;
  localparam int DSER_MDIV_LSB = 4;
  localparam int DSER_REF_OV_BIT = 2;
  localparam int DSER_MSEL_LSB = 0;
  // Field positions, link_error_threshold
  localparam int DSER_ERR_EN_BIT = 4;
  localparam int DSER_ERR_THR_LSB = 0;
  // Strap code bits
  localparam int DSER_COAX_BIT = 0;
  localparam int DSER_RATE20_BIT = 1;

  // Values after reset
  localparam logic [7:0] DSER_STRAP_STATUS_RST = 8'h00;
  localparam logic [7:0] DSER_AUDIO_DIV_RST = 8'h00;
  localparam logic [7:0] DSER_EQUALIZER_SETTING_STATUS_RST = 8'h00;
  localparam logic [3:0] DSER_ERR_THR_RST = 4'h3;
  localparam logic DSER_ERR_EN_RST = 1'b0;
  localparam logic [7:0] DSER_UNMAPPED_READ = 8'h00;

  // Writable bits of audio_clock_divider_select
  localparam logic [7:0] DSER_AUDIO_DIV_WMASK = 8'hf7;

  typedef enum logic [1:0] {
    DSER_ARR_DUAL,
    DSER_ARR_DUAL_SWAP,
    DSER_ARR_SINGLE,
    DSER_ARR_REPLICATE
  } dser_arrangement_t;

  // VCO output divide ratio from 3-bit selection
  function automatic logic [5:0] dser_mdiv_ratio(input logic [2:0] sel);
    case (sel)
      3'h0: dser_mdiv_ratio = 6'h20;
      3'h1: dser_mdiv_ratio = 6'h10;
      3'h2: dser_mdiv_ratio = 6'h08;
      3'h3: dser_mdiv_ratio = 6'h04;
      3'h4, 3'h5: dser_mdiv_ratio = 6'h02;
      default: dser_mdiv_ratio = 6'h01;
    endcase
  endfunction : dser_mdiv_ratio

  // Reference divide ratio from 2-bit selection
  function automatic logic [3:0] dser_msel_ratio(input logic [1:0] sel);
    case (sel)
      2'h0: dser_msel_ratio = 4'h1;
      2'h1: dser_msel_ratio = 4'h2;
      2'h2: dser_msel_ratio = 4'h4;
      default: dser_msel_ratio = 4'h8;
    endcase
  endfunction : dser_msel_ratio
endpackage : dser_pkg

/* File: include/dser_err_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface dser_err_if;
  logic count_en;
  logic [3:0] threshold;
  logic pix_en;
  logic link_err;
  logic lock_drop;
  logic [3:0] count;

  modport ctrl (output count_en, output threshold, output pix_en, output link_err,
                input lock_drop, input count);
  modport cnt (input count_en, input threshold, input pix_en, input link_err,
               output lock_drop, output count);
endinterface : dser_err_if
`default_nettype wire

/* File: logic/dser_err_counter.sv */
`timescale 1ns/1ns
`default_nettype none
module dser_err_counter (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic srst_in,
  // Control and errors
  dser_err_if.cnt err
);
  import dser_pkg::*;

  logic [3:0] count_r;
  logic [3:0] count_nxt;
  logic drop_r;
  logic hit;

  always_comb begin
    count_nxt = (count_r == 4'hf) ? count_r : count_r + 4'h1;
    // Threshold of zero behaves like one: the first error already reaches it
    hit = !err.count_en || (count_nxt >= err.threshold);
  end

  // Only moves on pixel clock enables
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      count_r <= 4'h0;
      drop_r <= 1'b0;
    end else begin
      drop_r <= 1'b0;
      if (err.pix_en && err.link_err) begin
        if (hit) begin
          drop_r <= 1'b1;
          count_r <= 4'h0;
        end else begin
          count_r <= count_nxt;
        end
      end
    end
  end

  assign err.lock_drop = drop_r;
  assign err.count = count_r;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  first_error_drop_a: assert property (
    (err.pix_en && err.link_err && !err.count_en) |=> drop_r && count_r == 4'h0)
    else $error("disabled counting did not drop lock on first error");
  threshold_drop_a: assert property (
    (err.pix_en && err.link_err && err.count_en && err.threshold > 4'h1
     && count_r == err.threshold - 4'h1) |=> drop_r)
    else $error("lock not dropped at threshold");
  below_thr_a: assert property (
    (err.pix_en && err.link_err && err.count_en && (count_r + 4'h1) < err.threshold
     && count_r != 4'hf) |=> !drop_r && count_r == $past(count_r) + 4'h1)
    else $error("error counted wrongly below threshold");
  pix_gate_a: assert property (
    !(err.pix_en && err.link_err) |=> !drop_r && $stable(count_r))
    else $error("counter moved without pixel enable and error");
endmodule : dser_err_counter
`default_nettype wire

/* File: logic/dser_regs.sv */
// Operation
// - Rate strap flag 1 only once latched
// - Rate strap: bit0 coax, bit1 20 Mbps
// - Rate strap field at bits 6 to 4
// - Output strap flag 1 only once latched
// - Output strap code selects four arrangements, repeating
// - Audio divider override picks software selection
// - VCO output divide 32 down to 1
// - Reference override replaces state machine ratio
// - Reference divide by 1, 2, 4, 8
// - Equalizer status: manual stages or adaptive
// - Port select shows second port status
// - Enable bit turns error counting on
// - Lock drops when count reaches threshold
// - Counting disabled: first error drops lock
// - Both link clocks and data lane checked
// - Error counter advances on pixel clock
// - Second port select steers reads
// - Stage one manual value in low bits
`timescale 1ns/1ns
`default_nettype none
module dser_regs (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic srst_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // Straps
  input wire logic [2:0] rate_strap_pin_in,
  input wire logic [2:0] output_strap_pin_in,
  // Port selection
  input wire logic second_port_select_in,
  // Equalizer, per port
  input wire logic [1:0] eq_bypass_in,
  input wire logic [5:0] eq_stage_one_in,
  input wire logic [5:0] eq_stage_two_in,
  input wire logic [5:0] aeq_port0_in,
  input wire logic [5:0] aeq_port1_in,
  // Clock dividers
  input wire logic [2:0] auto_audio_div_in,
  input wire logic [1:0] pll_state_machine_ref_div_in,
  output logic [2:0] audio_div_sel_out,
  output logic [5:0] audio_div_ratio_out,
  output logic [1:0] ref_div_sel_out,
  output logic [3:0] ref_div_ratio_out,
  // Link errors
  input wire logic pix_clk_en_in,
  input wire logic clk0_err_in,
  input wire logic clk1_err_in,
  input wire logic data_lane_err_in,
  output logic lock_drop_out,
  // Decoded straps
  output logic rate_is_20m_out,
  output logic cable_is_coax_out,
  output dser_pkg::dser_arrangement_t output_arrangement_out,
  output logic straps_latched_out
);
  import dser_pkg::*;

  typedef enum {DSER_ST_WAIT, DSER_ST_OUT, DSER_ST_RATE, DSER_ST_HOLD} dser_strap_st_t;

  dser_strap_st_t strap_st_r;
  logic [2:0] rate_cable_strap_decode_r;
  logic rate_strap_latched_r;
  logic [2:0] output_arrangement_strap_decode_r;
  logic output_strap_latched_r;
  logic [7:0] audio_div_r;
  logic count_en_r;
  logic [3:0] threshold_r;
  logic [7:0] rdata_r;
  logic rvalid_r;
  logic lock_drop_r;
  logic [2:0] audio_sel_r;
  logic [5:0] audio_ratio_r;
  logic [1:0] ref_sel_r;
  logic [3:0] ref_ratio_r;
  logic rate20_r;
  logic coax_r;
  dser_arrangement_t arr_r;
  logic [2:0] audio_sel_nxt;
  logic [1:0] ref_sel_nxt;
  logic [5:0] eq_port0;
  logic [5:0] eq_port1;
  logic [5:0] equalizer_setting;
  logic [7:0] rdata_nxt;

  dser_err_if err_bus ();

  // One strap per cycle; the decodes hold until the next reset
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      strap_st_r <= DSER_ST_WAIT;
      output_arrangement_strap_decode_r <= 3'h0;
      output_strap_latched_r <= 1'b0;
      rate_cable_strap_decode_r <= 3'h0;
      rate_strap_latched_r <= 1'b0;
    end else begin
      case (strap_st_r)
        DSER_ST_WAIT: begin
          strap_st_r <= DSER_ST_OUT;
        end
        DSER_ST_OUT: begin
          output_arrangement_strap_decode_r <= output_strap_pin_in;
          output_strap_latched_r <= 1'b1;
          strap_st_r <= DSER_ST_RATE;
        end
        DSER_ST_RATE: begin
          rate_cable_strap_decode_r <= rate_strap_pin_in;
          rate_strap_latched_r <= 1'b1;
          strap_st_r <= DSER_ST_HOLD;
        end
        DSER_ST_HOLD: begin
          strap_st_r <= DSER_ST_HOLD;
        end
        default: begin
          strap_st_r <= DSER_ST_WAIT;
        end
      endcase
    end
  end

  // Decoded strap outputs; upper code bit only repeats the sequence
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      rate20_r <= 1'b0;
      coax_r <= 1'b0;
      arr_r <= DSER_ARR_DUAL;
    end else begin
      rate20_r <= rate_cable_strap_decode_r[DSER_RATE20_BIT];
      coax_r <= rate_cable_strap_decode_r[DSER_COAX_BIT];
      arr_r <= dser_arrangement_t'(output_arrangement_strap_decode_r[1:0]);
    end
  end

  // Register writes
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      audio_div_r <= DSER_AUDIO_DIV_RST;
      count_en_r <= DSER_ERR_EN_RST;
      threshold_r <= DSER_ERR_THR_RST;
    end else if (reg_wr_in) begin
      if (reg_addr_in == DSER_AUDIO_DIV_OFS) begin
        audio_div_r <= reg_wdata_in & DSER_AUDIO_DIV_WMASK;
      end
      if (reg_addr_in == DSER_LINK_ERR_OFS) begin
        count_en_r <= reg_wdata_in[DSER_ERR_EN_BIT];
        threshold_r <= reg_wdata_in[DSER_ERR_THR_LSB +: 4];
      end
    end
  end

  // Divider selection and ratios
  always_comb begin
    audio_sel_nxt = audio_div_r[DSER_AUDIO_OV_BIT] ? audio_div_r[DSER_MDIV_LSB +: 3]
                                                   : auto_audio_div_in;
    ref_sel_nxt = audio_div_r[DSER_REF_OV_BIT] ? audio_div_r[DSER_MSEL_LSB +: 2]
                                               : pll_state_machine_ref_div_in;
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      audio_sel_r <= 3'h0;
      audio_ratio_r <= dser_mdiv_ratio(3'h0);
      ref_sel_r <= 2'h0;
      ref_ratio_r <= dser_msel_ratio(2'h0);
    end else begin
      audio_sel_r <= audio_sel_nxt;
      audio_ratio_r <= dser_mdiv_ratio(audio_sel_nxt);
      ref_sel_r <= ref_sel_nxt;
      ref_ratio_r <= dser_msel_ratio(ref_sel_nxt);
    end
  end

  // Equalizer status per port: {stage two, stage one} when bypassed
  always_comb begin
    eq_port0 = eq_bypass_in[0] ? {eq_stage_two_in[2:0], eq_stage_one_in[2:0]}
                               : aeq_port0_in;
    eq_port1 = eq_bypass_in[1] ? {eq_stage_two_in[5:3], eq_stage_one_in[5:3]}
                               : aeq_port1_in;
    equalizer_setting = second_port_select_in ? eq_port1 : eq_port0;
  end

  // Read mux; reserved bits and unmapped offsets read as zero
  always_comb begin
    rdata_nxt = DSER_UNMAPPED_READ;
    case (reg_addr_in)
      DSER_STRAP_STATUS_OFS: begin
        rdata_nxt[DSER_RATE_DONE_BIT] = rate_strap_latched_r;
        rdata_nxt[DSER_RATE_LSB +: 3] = rate_cable_strap_decode_r;
        rdata_nxt[DSER_OUT_DONE_BIT] = output_strap_latched_r;
        rdata_nxt[DSER_OUT_LSB +: 3] = output_arrangement_strap_decode_r;
      end
      DSER_AUDIO_DIV_OFS: begin
        rdata_nxt = audio_div_r;
      end
      DSER_EQUALIZER_SETTING_STATUS_OFS: begin
        rdata_nxt = {2'h0, equalizer_setting};
      end
      DSER_LINK_ERR_OFS: begin
        rdata_nxt[DSER_ERR_EN_BIT] = count_en_r;
        rdata_nxt[DSER_ERR_THR_LSB +: 4] = threshold_r;
      end
      default: begin
        rdata_nxt = DSER_UNMAPPED_READ;
      end
    endcase
  end

  // Read data held until the next read
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      rdata_r <= DSER_UNMAPPED_READ;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= reg_rd_in;
      if (reg_rd_in) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  // Link error counter on pixel clock enables
  assign err_bus.count_en = count_en_r;
  assign err_bus.threshold = threshold_r;
  assign err_bus.pix_en = pix_clk_en_in;
  assign err_bus.link_err = clk0_err_in | clk1_err_in | data_lane_err_in;

  dser_err_counter u_err_counter (
    .core_clk_in (core_clk_in),
    .srst_in (srst_in),
    .err (err_bus.cnt)
  );

  // Extra stage keeps the top output a flop of this module
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      lock_drop_r <= 1'b0;
    end else begin
      lock_drop_r <= err_bus.lock_drop;
    end
  end

  assign reg_rdata_out = rdata_r;
  assign reg_rvalid_out = rvalid_r;
  assign audio_div_sel_out = audio_sel_r;
  assign audio_div_ratio_out = audio_ratio_r;
  assign ref_div_sel_out = ref_sel_r;
  assign ref_div_ratio_out = ref_ratio_r;
  assign lock_drop_out = lock_drop_r;
  assign rate_is_20m_out = rate20_r;
  assign cable_is_coax_out = coax_r;
  assign output_arrangement_out = arr_r;
  assign straps_latched_out = rate_strap_latched_r;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  sequence strap_release_s;
    $fell(srst_in) ##0 !rate_strap_latched_r && !output_strap_latched_r;
  endsequence

  strap_latch_order_a: assert property (
    strap_release_s |=> !output_strap_latched_r
                        ##1 (output_strap_latched_r && !rate_strap_latched_r)
                        ##1 rate_strap_latched_r)
    else $error("straps not latched in order after reset");
  rate_done_flag_a: assert property (
    (reg_rd_in && reg_addr_in == DSER_STRAP_STATUS_OFS)
    |=> reg_rdata_out[DSER_RATE_DONE_BIT] == $past(rate_strap_latched_r)
        && reg_rdata_out[6:4] == $past(rate_cable_strap_decode_r))
    else $error("rate strap field or flag read wrongly");
  out_done_flag_a: assert property (
    (reg_rd_in && reg_addr_in == DSER_STRAP_STATUS_OFS)
    |=> reg_rdata_out[DSER_OUT_DONE_BIT] == $past(output_strap_latched_r)
        && reg_rdata_out[2:0] == $past(output_arrangement_strap_decode_r))
    else $error("output strap field or flag read wrongly");
  strap_hold_a: assert property (
    rate_strap_latched_r |=> $stable(rate_cable_strap_decode_r)
                             && $stable(output_arrangement_strap_decode_r))
    else $error("latched strap changed");
  audio_override_a: assert property (
    audio_div_r[DSER_AUDIO_OV_BIT] && $stable(audio_div_r)
    |=> audio_div_sel_out == $past(audio_div_r[6:4]))
    else $error("audio divider override ignored");
  ref_auto_a: assert property (
    !audio_div_r[DSER_REF_OV_BIT] |=> ref_div_sel_out == $past(pll_state_machine_ref_div_in))
    else $error("reference divider not from state machine");
  ref_ratio_a: assert property (
    ref_div_ratio_out == (4'h1 << ref_div_sel_out))
    else $error("reference divide ratio wrong");
  audio_ratio_a: assert property (
    audio_div_sel_out < 3'h4 |-> audio_div_ratio_out == (6'h20 >> audio_div_sel_out))
    else $error("audio divide ratio wrong");
  eq_port_sel_a: assert property (
    (reg_rd_in && reg_addr_in == DSER_EQUALIZER_SETTING_STATUS_OFS && second_port_select_in
     && eq_bypass_in[1]) |=> reg_rdata_out == {2'h0, $past(eq_stage_two_in[5:3]),
                                               $past(eq_stage_one_in[5:3])})
    else $error("second port equalizer status wrong");
  err_path_a: assert property (
    (pix_clk_en_in && data_lane_err_in && !count_en_r) |=> ##1 lock_drop_out)
    else $error("data lane error did not drop lock");
  drop_clear_a: assert property (
    err_bus.lock_drop |-> err_bus.count == 4'h0)
    else $error("error count not cleared on lock drop");
endmodule : dser_regs
`default_nettype wire

/* File: testbench/dser_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module dser_host_model (
  // Clock
  input wire logic core_clk_in,
  // Register port
  output logic [7:0] reg_addr_out,
  output logic reg_wr_out,
  output logic [7:0] reg_wdata_out,
  output logic reg_rd_out
);
  initial begin
    reg_addr_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_wdata_out = 8'h00;
    reg_rd_out = 1'b0;
  end

  // Entered at a falling edge; the strobe is taken at the next rising edge
  task automatic access(input logic [7:0] addr, input logic wr, input logic [7:0] data,
                        input int idle);
    reg_addr_out = addr;
    reg_wdata_out = data;
    reg_wr_out = wr;
    reg_rd_out = ~wr;
    @(negedge core_clk_in);
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    // Released lines must not keep looking valid
    reg_addr_out = ~addr;
    reg_wdata_out = ~data;
    @(negedge core_clk_in);
    repeat (idle) @(negedge core_clk_in);
  endtask : access
endmodule : dser_host_model
`default_nettype wire

/* File: testbench/dser_regs_test.sv */
`timescale 1ns/1ns
`default_nettype none
module dser_regs_test;
  import dser_pkg::*;
  logic core_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic [7:0] reg_wdata;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic [2:0] rate_pin;
  logic [2:0] out_pin;
  logic port_sel;
  logic [1:0] eq_bypass;
  logic [5:0] stage_one;
  logic [5:0] stage_two;
  logic [5:0] aeq0;
  logic [5:0] aeq1;
  logic [2:0] auto_audio;
  logic [1:0] auto_ref;
  logic [2:0] audio_sel;
  logic [5:0] audio_ratio;
  logic [1:0] ref_sel;
  logic [3:0] ref_ratio;
  logic pix_en;
  logic err0;
  logic err1;
  logic err_dl;
  logic lock_drop;
  logic rate20;
  logic coax;
  dser_arrangement_t arr;
  logic latched;
  int num_errors = 0;
  int n_checks = 0;
  logic [7:0] exp_q[$];
  logic [31:0] lfsr = 32'h8038a846;

  always #5 core_clk_in = ~core_clk_in;

  dser_host_model host_u (.core_clk_in(core_clk_in), .reg_addr_out(reg_addr),
    .reg_wr_out(reg_wr), .reg_wdata_out(reg_wdata), .reg_rd_out(reg_rd));

  dser_regs dut_u (.core_clk_in(core_clk_in), .srst_in(srst_in), .reg_addr_in(reg_addr),
    .reg_wr_in(reg_wr), .reg_wdata_in(reg_wdata), .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata), .reg_rvalid_out(reg_rvalid), .rate_strap_pin_in(rate_pin),
    .output_strap_pin_in(out_pin), .second_port_select_in(port_sel),
    .eq_bypass_in(eq_bypass), .eq_stage_one_in(stage_one), .eq_stage_two_in(stage_two),
    .aeq_port0_in(aeq0), .aeq_port1_in(aeq1), .auto_audio_div_in(auto_audio),
    .pll_state_machine_ref_div_in(auto_ref), .audio_div_sel_out(audio_sel),
    .audio_div_ratio_out(audio_ratio), .ref_div_sel_out(ref_sel),
    .ref_div_ratio_out(ref_ratio), .pix_clk_en_in(pix_en), .clk0_err_in(err0),
    .clk1_err_in(err1), .data_lane_err_in(err_dl), .lock_drop_out(lock_drop),
    .rate_is_20m_out(rate20), .cable_is_coax_out(coax), .output_arrangement_out(arr),
    .straps_latched_out(latched));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  function automatic logic [5:0] mdiv_exp(input logic [2:0] s);
    if (s < 3'h4) return 6'h20 >> s;
    return (s < 3'h6) ? 6'h02 : 6'h01;
  endfunction : mdiv_exp

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic finish_test;
    if (exp_q.size() != 0) begin
      num_errors++;
      $display("Error %0t: reads left without answer", $time);
    end
    $display("Checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    exp_q.push_back(exp);
    host_u.access(addr, 1'b0, 8'h00, 0);
  endtask : rd

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    host_u.access(addr, 1'b1, data, 0);
  endtask : wr

  task automatic link_err(input logic [2:0] which, input logic pix);
    pix_en = pix;
    {err0, err1, err_dl} = which;
    @(negedge core_clk_in);
    pix_en = 1'b0;
    {err0, err1, err_dl} = 3'b000;
  endtask : link_err

  // Drop is due one edge after the edge that takes the error
  task automatic expect_drop(input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (4) begin
      @(posedge core_clk_in);
      #1;
      if (lock_drop === 1'b1) seen = 1'b1;
    end
    @(negedge core_clk_in);
    check({7'h00, seen}, {7'h00, exp}, "lock drop");
  endtask : expect_drop

  // Scoreboard: rvalid stands one cycle, so one falling edge sees it
  always @(negedge core_clk_in) begin
    if (reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("Error %0t: unexpected read answer", $time);
      end else begin
        check(reg_rdata, exp_q.pop_front(), "read data");
      end
    end
  end

  initial begin
    repeat (20000) @(posedge core_clk_in);
    num_errors++;
    $display("Error %0t: run did not complete", $time);
    finish_test();
  end

  initial begin
    int thr_list[3];
    int p;
    logic [5:0] exp_eq;
    thr_list = '{2, 3, 5};
    {rate_pin, out_pin, port_sel, eq_bypass} = 9'h000;
    {stage_one, stage_two, aeq0, aeq1} = 24'h000000;
    {auto_audio, auto_ref, pix_en, err0, err1, err_dl} = 9'h000;
    for (int i = 0; i < 8; i++) begin
      rate_pin = i[2:0];
      out_pin = ~i[2:0];
      srst_in = 1'b1;
      repeat (6) @(negedge core_clk_in);
      srst_in = 1'b0;
      rd(DSER_STRAP_STATUS_OFS, 8'h00);
      check({7'h00, latched}, 8'h00, "latched flag early");
      repeat (4) @(negedge core_clk_in);
      rate_pin = ~rate_pin;
      out_pin = ~out_pin;
      rd(DSER_STRAP_STATUS_OFS, {1'b1, i[2:0], 1'b1, ~i[2:0]});
      check({7'h00, rate20}, {7'h00, i[1]}, "rate");
      check({7'h00, coax}, {7'h00, i[0]}, "cable");
      check({6'h00, arr}, {6'h00, ~i[1:0]}, "arrangement");
      check({7'h00, latched}, 8'h01, "latched flag");
    end
    rd(DSER_AUDIO_DIV_OFS, 8'h00);
    rd(DSER_LINK_ERR_OFS, 8'h03);
    rd(8'h50, 8'h00);
    for (int i = 0; i < 8; i++) begin
      lfsr = lfsr_next(lfsr);
      auto_audio = lfsr[2:0];
      auto_ref = lfsr[4:3];
      wr(DSER_AUDIO_DIV_OFS, {1'b1, i[2:0], 2'b11, i[1:0]});
      check({5'h00, audio_sel}, {5'h00, i[2:0]}, "audio sel");
      check({2'h0, audio_ratio}, {2'h0, mdiv_exp(i[2:0])}, "audio ratio");
      check({6'h00, ref_sel}, {6'h00, i[1:0]}, "ref sel");
      check({4'h0, ref_ratio}, {4'h0, 4'h1 << i[1:0]}, "ref ratio");
      rd(DSER_AUDIO_DIV_OFS, {1'b1, i[2:0], 2'b01, i[1:0]});
      wr(DSER_AUDIO_DIV_OFS, {1'b0, i[2:0], 2'b10, i[1:0]});
      check({5'h00, audio_sel}, {5'h00, auto_audio}, "auto audio sel");
      check({2'h0, audio_ratio}, {2'h0, mdiv_exp(auto_audio)}, "auto ratio");
      check({6'h00, ref_sel}, {6'h00, auto_ref}, "auto ref sel");
      check({4'h0, ref_ratio}, {4'h0, 4'h1 << auto_ref}, "auto ref ratio");
    end
    for (int k = 0; k < 8; k++) begin
      lfsr = lfsr_next(lfsr);
      {stage_one, stage_two, aeq0, aeq1} = lfsr[23:0];
      eq_bypass = k[1:0];
      port_sel = k[2];
      p = k / 4;
      repeat (2) @(negedge core_clk_in);
      exp_eq = eq_bypass[p] ? {stage_two[p*3+:3], stage_one[p*3+:3]} : (p ? aeq1 : aeq0);
      rd(DSER_EQUALIZER_SETTING_STATUS_OFS, {2'b00, exp_eq});
    end
    wr(DSER_EQUALIZER_SETTING_STATUS_OFS, 8'hff);
    wr(DSER_STRAP_STATUS_OFS, 8'h00);
    rd(DSER_EQUALIZER_SETTING_STATUS_OFS, {2'b00, exp_eq});
    rd(DSER_STRAP_STATUS_OFS, 8'hf8);
    wr(DSER_LINK_ERR_OFS, 8'hf5);
    rd(DSER_LINK_ERR_OFS, 8'h15);
    foreach (thr_list[n]) begin
      wr(DSER_LINK_ERR_OFS, 8'h10 | 8'(thr_list[n]));
      link_err(3'b111, 1'b0);
      expect_drop(1'b0);
      for (int e = 1; e <= thr_list[n]; e++) begin
        link_err(3'b001 << (e % 3), 1'b1);
        expect_drop(e == thr_list[n]);
      end
    end
    wr(DSER_LINK_ERR_OFS, 8'h0f);
    link_err(3'b010, 1'b1);
    expect_drop(1'b1);
    link_err(3'b001, 1'b1);
    expect_drop(1'b1);
    repeat (4) @(negedge core_clk_in);
    finish_test();
  end
endmodule : dser_regs_test
`default_nettype wire
